// file: rtl/ustx_pkg.sv
// Shared constants, types and helper functions of the asynchronous serial transmitter.
// Operation
// - Line idles at mark; start bit space, 8 or 9 data bits, mark stop bits.
// - Characters are serialized least significant data bit first.
// - Every bit lasts exactly one bit period with no return to neutral level.
// - Bit timing comes from the system clock via an 8-bit or 16-bit divider.
// - Transmit path is independent but uses the common format and rate.
// - No hardware parity; software puts parity into the ninth data bit.
// - Sending needs transmitter on, clocked mode off, port on; port on drives pin.
// - A written character starts sending; an empty shifter takes it at once.
// - A queued character waits for the stop bit, then loads and starts immediately.
// - Polarity invert clear gives high-true levels, set gives low-true levels.
// - Buffer free flag is set while the path is enabled, unless shifter busy and another character queued.
// - Flag does not drop on the write; it is updated two cycles later.
// - Buffer free flag is read-only and kept by hardware alone.
// - Buffer free flag ignores the interrupt mask; the mask only gates requests.
// - Shifter empty clears on load, stays clear through stop bit, no interrupt.
// - Nine-bit select sends ninth bit value as MSB, captured with the write.
package ustx_pkg;

	// System clock rate
	localparam int unsigned USTX_CLK_HZ = 20_000_000;

	// Line levels before polarity
	localparam logic USTX_MARK = 1'b1;
	localparam logic USTX_SPACE = 1'b0;

	// Character lengths
	localparam logic [3:0] USTX_BITS_8 = 4'h8;
	localparam logic [3:0] USTX_BITS_9 = 4'h9;
	localparam logic [3:0] USTX_ONE = 4'h1;

	// Data path widths and FIFO depth
	localparam int USTX_CHAR_W = 9;
	localparam int USTX_FIFO_DEPTH = 4;
	localparam logic [15:0] USTX_CNT_ONE = 16'h0001;

	// Shifter sequence, one-hot
	typedef enum logic [3:0] {
		USTX_IDLE = 4'b0001,
		USTX_START = 4'b0010,
		USTX_DATA = 4'b0100,
		USTX_STOP = 4'b1000
	} ustx_state_t;

	// Static configuration bits from software
	typedef struct packed {
		logic port_on;
		logic transmitter_on;
		logic clocked_mode_select;
		logic line_polarity_invert;
		logic nine_bit_select;
		logic ninth_bit_value;
		logic rate_16bit;
		logic transmit_irq_mask;
		logic [15:0] rate_divisor;
	} ustx_cfg_t;

	// Complete state of the transmitter
	typedef struct packed {
		ustx_state_t st;
		logic [15:0] baud_cnt;
		logic [3:0] bit_cnt;
		logic [3:0] stop_cnt;
		logic [3:0] nbits;
		logic [USTX_CHAR_W-1:0] shifter;
		logic hold_valid;
		logic [USTX_CHAR_W-1:0] hold;
		logic line;
		logic oe;
		logic free_flag;
		logic empty;
		logic irq;
	} ustx_regs_t;

	localparam ustx_regs_t USTX_REGS_RST = '{st: USTX_IDLE, baud_cnt: 16'h0000, bit_cnt: 4'h0,
		stop_cnt: 4'h0, nbits: USTX_BITS_8, shifter: 9'h000, hold_valid: 1'b0, hold: 9'h000,
		line: USTX_MARK, oe: 1'b0, free_flag: 1'b0, empty: 1'b1, irq: 1'b0};

	// Terminal count of the divider; 8-bit mode ignores the high byte
	function automatic logic [15:0] ustx_divisor(input logic wide, input logic [15:0] div);
		ustx_divisor = wide ? div : {8'h00, div[7:0]};
	endfunction : ustx_divisor

	// Line level for a sequence state, before and after inversion
	function automatic logic ustx_level(input ustx_state_t st, input logic bit0, input logic inv);
		logic lvl;
		lvl = USTX_MARK;
		if (st == USTX_START) begin
			lvl = USTX_SPACE;
		end else if (st == USTX_DATA) begin
			lvl = bit0;
		end
		ustx_level = lvl ^ inv;
	endfunction : ustx_level

endpackage : ustx_pkg

// file: rtl/ustx_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and registered flags.
module ustx_fifo #(
	parameter int W = 9,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import ustx_pkg::*;

	// Pointers wrap naturally, so DEPTH must be a power of two
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = AW'(DEPTH) == '0 ? {1'b1, {AW{1'b0}}} : (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic ready;
		logic valid;
	} ustx_fifo_regs_t;

	localparam ustx_fifo_regs_t FIFO_RST = '{mem: '0, wp: '0, rp: '0, cnt: '0, ready: 1'b1, valid: 1'b0};

	ustx_fifo_regs_t s_q;
	ustx_fifo_regs_t s_d;
	logic push;
	logic pop;

	// Flags are kept as flops so the ready seen upstream has no logic in front of it
	assign in_ready = s_q.ready;
	assign out_valid = s_q.valid;
	assign out_data = s_q.mem[s_q.rp];

	// Next state: push, pop, flush
	always_comb begin
		s_d = s_q;
		push = in_valid & s_q.ready;
		pop = out_ready & s_q.valid;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = s_q.rp + 1'b1;
		end
		s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		s_d.ready = (s_d.cnt != FULL_CNT);
		s_d.valid = (s_d.cnt != '0);
		if (flush) begin
			s_d = FIFO_RST;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= FIFO_RST;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : ustx_fifo

// file: rtl/ustx_tx.sv
// Asynchronous NRZ serial transmitter: holding buffer, shifter, divider and status flags.
module ustx_tx #(
	parameter logic [3:0] STOP_BITS = 4'h1,
	parameter int FIFO_DEPTH = ustx_pkg::USTX_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration
	input wire ustx_pkg::ustx_cfg_t cfg,
	// Character write port
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	output logic wr_ready,
	// Serial line
	output logic tx_pin_o,
	output logic tx_pin_oe,
	// Status
	output logic transmit_buffer_free_flag,
	output logic shifter_empty,
	output logic tx_irq_req
);
	import ustx_pkg::*;

	ustx_regs_t s_q;
	ustx_regs_t s_d;
	logic en;
	logic [15:0] div;
	logic bit_tick;
	logic last_data;
	logic last_stop;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [USTX_CHAR_W-1:0] fifo_out_data;

	// Transmit path is live only in asynchronous mode with port and transmitter on
	assign en = cfg.port_on & cfg.transmitter_on & ~cfg.clocked_mode_select;
	assign div = ustx_divisor(cfg.rate_16bit, cfg.rate_divisor);
	assign bit_tick = (s_q.baud_cnt == div);
	assign last_data = (s_q.bit_cnt == s_q.nbits - USTX_ONE);
	assign last_stop = (s_q.stop_cnt == STOP_BITS - USTX_ONE);

	// Holding buffer pulls from the FIFO only while it is empty
	assign fifo_out_ready = en & ~s_q.hold_valid;

	// The ninth bit is captured with the low byte, so it must be set up before the write
	ustx_fifo #(
		.W(USTX_CHAR_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.flush(~cfg.port_on),
		.in_valid(wr_valid),
		.in_ready(fifo_in_ready),
		.in_data({cfg.ninth_bit_value, wr_data}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// Outputs straight from the state flops
	assign tx_pin_o = s_q.line;
	assign tx_pin_oe = s_q.oe;
	assign transmit_buffer_free_flag = s_q.free_flag;
	assign shifter_empty = s_q.empty;
	assign tx_irq_req = s_q.irq;
	assign wr_ready = fifo_in_ready;

	// Next state of the shifter sequence, buffer and flags
	always_comb begin
		s_d = s_q;
		// The divider only runs inside a frame, so a new frame always starts on a full period
		if (s_q.st != USTX_IDLE) begin
			s_d.baud_cnt = bit_tick ? 16'h0000 : s_q.baud_cnt + USTX_CNT_ONE;
		end
		unique case (s_q.st)
			USTX_IDLE: begin
				// Empty shifter takes a waiting character at once
				if (s_q.hold_valid) begin
					s_d.st = USTX_START;
					s_d.shifter = s_q.hold;
					s_d.hold_valid = 1'b0;
					s_d.baud_cnt = 16'h0000;
					s_d.nbits = cfg.nine_bit_select ? USTX_BITS_9 : USTX_BITS_8;
				end
			end
			USTX_START: begin
				if (bit_tick) begin
					s_d.st = USTX_DATA;
					s_d.bit_cnt = 4'h0;
				end
			end
			USTX_DATA: begin
				// Shift right so bit 0 is always the one on the line
				if (bit_tick) begin
					s_d.shifter = {1'b0, s_q.shifter[USTX_CHAR_W-1:1]};
					s_d.bit_cnt = s_q.bit_cnt + USTX_ONE;
					if (last_data) begin
						s_d.st = USTX_STOP;
						s_d.stop_cnt = 4'h0;
					end
				end
			end
			USTX_STOP: begin
				if (bit_tick) begin
					s_d.stop_cnt = s_q.stop_cnt + USTX_ONE;
					if (last_stop) begin
						// Back-to-back: queued character loads in the cycle the stop bit ends
						if (s_q.hold_valid) begin
							s_d.st = USTX_START;
							s_d.shifter = s_q.hold;
							s_d.hold_valid = 1'b0;
							s_d.nbits = cfg.nine_bit_select ? USTX_BITS_9 : USTX_BITS_8;
						end else begin
							s_d.st = USTX_IDLE;
						end
					end
				end
			end
		endcase
		// Refill the holding buffer; it was empty, so no clash with the load above
		if (fifo_out_valid & fifo_out_ready) begin
			s_d.hold_valid = 1'b1;
			s_d.hold = fifo_out_data;
		end
		// Disabling the transmitter drops any character in flight
		if (!en) begin
			s_d = USTX_REGS_RST;
		end
		s_d.line = ustx_level(s_d.st, s_d.shifter[0], cfg.line_polarity_invert);
		s_d.oe = cfg.port_on;
		// Free while enabled unless the shifter is busy and another character waits; the write itself
		// reaches this term only through the FIFO, two cycles later
		s_d.free_flag = en & ~(~s_q.empty & (s_q.hold_valid | fifo_out_valid));
		s_d.empty = (s_d.st == USTX_IDLE);
		s_d.irq = s_d.free_flag & cfg.transmit_irq_mask;
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= USTX_REGS_RST;
		end else begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Frame steps used by the assertions below
	sequence s_load;
		s_q.st == USTX_IDLE && s_q.hold_valid && en;
	endsequence

	sequence s_stop_end_queued;
		s_q.st == USTX_STOP && bit_tick && last_stop && s_q.hold_valid && en;
	endsequence

	sequence s_frame_begins;
		s_q.st == USTX_START && !shifter_empty && s_q.baud_cnt == 16'h0000;
	endsequence

	// Start bit is space
	property p_start_space;
		!$past(rst) && s_q.st == USTX_START |-> tx_pin_o == (USTX_SPACE ^ $past(cfg.line_polarity_invert));
	endproperty
	a_start_space: assert property (p_start_space) else $error("start bit not at space level");

	// Stop and idle are mark
	property p_stop_mark;
		!$past(rst) && (s_q.st == USTX_STOP || s_q.st == USTX_IDLE) |->
			tx_pin_o == (USTX_MARK ^ $past(cfg.line_polarity_invert));
	endproperty
	a_stop_mark: assert property (p_stop_mark) else $error("stop or idle not at mark level");

	// Line carries shifter bit 0 during data
	property p_lsb_first;
		!$past(rst) && s_q.st == USTX_DATA |-> tx_pin_o == (s_q.shifter[0] ^ $past(cfg.line_polarity_invert));
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("data bit not lsb first");

	// Divider counts up by one between ticks inside a frame
	property p_divider_step;
		s_q.st != USTX_IDLE && !bit_tick && en && $stable(div) |=>
			s_q.baud_cnt == $past(s_q.baud_cnt) + USTX_CNT_ONE;
	endproperty
	a_divider_step: assert property (p_divider_step) else $error("divider skipped a count");

	// A tick in the start bit moves to data with a fresh period
	property p_start_to_data;
		s_q.st == USTX_START && bit_tick && en |=> s_q.st == USTX_DATA && s_q.baud_cnt == 16'h0000;
	endproperty
	a_start_to_data: assert property (p_start_to_data) else $error("start bit did not end on tick");

	// Empty shifter loads immediately
	property p_load_now;
		s_load |=> s_frame_begins;
	endproperty
	a_load_now: assert property (p_load_now) else $error("waiting character not loaded");

	// Queued character follows the stop bit with no gap
	property p_back_to_back;
		s_stop_end_queued |=> s_frame_begins ##0 !s_q.hold_valid[*1];
	endproperty
	a_back_to_back: assert property (p_back_to_back) else $error("queued character not started");

	// Disabled path stays idle and empty
	property p_disabled;
		!en |=> s_q.st == USTX_IDLE && !s_q.hold_valid && shifter_empty && !transmit_buffer_free_flag;
	endproperty
	a_disabled: assert property (p_disabled) else $error("transmitter active while disabled");

	// Driver enable follows the port switch
	property p_driver;
		!$past(rst) |-> tx_pin_oe == $past(cfg.port_on);
	endproperty
	a_driver: assert property (p_driver) else $error("driver enable wrong");

	// While enabled, flag low only while busy with a character queued
	property p_flag_low;
		!$past(rst) && !transmit_buffer_free_flag && $past(en) |->
			$past(!s_q.empty && (s_q.hold_valid || fifo_out_valid));
	endproperty
	a_flag_low: assert property (p_flag_low) else $error("buffer free flag cleared wrongly");

	// A write while the shifter is empty never clears the flag in the next cycle
	property p_flag_late;
		transmit_buffer_free_flag && wr_valid && wr_ready && en && s_q.empty |=> transmit_buffer_free_flag;
	endproperty
	a_flag_late: assert property (p_flag_late) else $error("flag dropped on the write");

	// Interrupt request gated by the mask, flag is not
	property p_irq_gate;
		!$past(rst) |-> tx_irq_req == (transmit_buffer_free_flag && $past(cfg.transmit_irq_mask));
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt request not flag and mask");

	// Shifter empty comes back only once the last stop bit is out, or the path is switched off
	property p_empty;
		$rose(shifter_empty) |-> $past(!en || (s_q.st == USTX_STOP && bit_tick && last_stop));
	endproperty
	a_empty: assert property (p_empty) else $error("shifter empty status wrong");

	// Character length follows the nine-bit select at load
	property p_length;
		s_load |=> s_q.nbits == ($past(cfg.nine_bit_select) ? USTX_BITS_9 : USTX_BITS_8);
	endproperty
	a_length: assert property (p_length) else $error("character length wrong");

endmodule : ustx_tx

// file: tb/ustx_rx_model.sv
// Behavioural remote receiver that decodes frames and checks every bit window.
module ustx_rx_model (
	// Clock and line
	input wire logic clk,
	input wire logic line,
	// Expected format
	input wire logic [16:0] per,
	input wire logic inv,
	input wire logic nine,
	// Decoded character
	output logic rx_valid,
	output logic [8:0] rx_data,
	output logic rx_err,
	output logic [15:0] rx_gap
);
	timeunit 1ns;
	timeprecision 1ns;
	logic lvl;
	logic err;
	logic [8:0] d;
	int nb;
	int gap = 0;
	// Hunt for a start bit, then sample every clock of each bit window
	initial begin
		rx_valid = 1'b0;
		rx_data = 9'h000;
		rx_err = 1'b0;
		rx_gap = 16'h0000;
		forever begin
			@(posedge clk);
			rx_valid <= 1'b0;
			if ((line ^ inv) !== 1'b0) begin
				gap++;
			end else begin
				err = 1'b0;
				d = 9'h000;
				nb = nine ? 11 : 10;
				for (int b = 0; b < nb; b++) begin
					if (b > 0) @(posedge clk);
					lvl = line ^ inv;
					// A change inside the window means a bit of the wrong length
					repeat (per - 1) begin
						@(posedge clk);
						if ((line ^ inv) !== lvl) err = 1'b1;
					end
					if (b == 0 && lvl !== 1'b0) err = 1'b1;
					if (b == nb - 1 && lvl !== 1'b1) err = 1'b1;
					if (b > 0 && b < nb - 1) d[b - 1] = lvl;
				end
				rx_data <= d;
				rx_err <= err;
				rx_gap <= gap[15:0];
				rx_valid <= 1'b1;
				gap = 0;
			end
		end
	end
endmodule : ustx_rx_model

// file: tb/tb_async_serial_transmitter.sv
// Self-checking bench of the serial transmitter against a remote receiver model.
module tb_async_serial_transmitter import ustx_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, wr_valid, wr_ready, tx_pin_o, tx_pin_oe, free_flag, empty_flag, irq_req, line, inv_q;
	logic rx_valid, rx_err;
	logic [7:0] wr_data;
	logic [8:0] rx_data;
	logic [9:0] cur;
	logic [15:0] rx_gap;
	logic [16:0] per;
	logic [31:0] seed;
	logic [9:0] exp_q[$];
	ustx_cfg_t cfg;
	int mismatches = 0;
	int compares = 0;
	int stalls = 0;
	// Released line floats up to mark through the pull-up
	assign line = tx_pin_oe ? tx_pin_o : 1'b1;
	// Bit period; 8-bit mode ignores the high divisor byte
	assign per = cfg.rate_16bit ? {1'b0, cfg.rate_divisor} + 17'h00001
		: {9'h000, cfg.rate_divisor[7:0]} + 17'h00001;
	ustx_tx ustx_tx_i (.clk(clk), .rst(rst), .cfg(cfg), .wr_valid(wr_valid), .wr_data(wr_data),
		.wr_ready(wr_ready), .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe), .transmit_buffer_free_flag(free_flag),
		.shifter_empty(empty_flag), .tx_irq_req(irq_req));
	ustx_rx_model ustx_rx_model_i (.clk(clk), .line(line), .per(per), .inv(inv_q), .nine(cfg.nine_bit_select),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err), .rx_gap(rx_gap));
	// Clock of 50 ns
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Pin is registered, so the receiver follows polarity one clock late
	always @(posedge clk) inv_q <= cfg.line_polarity_invert;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk_bit(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit
	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	task automatic give_up();
		mismatches++;
		tally_and_finish();
	endtask : give_up
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	// Writes n random characters back to back, holding valid while the FIFO refuses
	task automatic burst(input int n, input logic keep);
		int k;
		for (int i = 0; i < n; i++) begin
			seed = lfsr(seed);
			wr_data = seed[7:0];
			cfg.ninth_bit_value = seed[8];
			wr_valid = 1'b1;
			k = 0;
			do begin
				@(posedge clk);
				k++;
			end while (wr_ready !== 1'b1 && k < 20000);
			if (wr_ready !== 1'b1) give_up();
			stalls += k - 1;
			if (keep) exp_q.push_back({exp_q.size() > 0, cfg.nine_bit_select & seed[8], seed[7:0]});
			#1;
		end
		wr_valid = 1'b0;
	endtask : burst
	// Waits until every expected character arrived and the shifter is idle
	task automatic drain();
		int k;
		k = 0;
		while ((exp_q.size() != 0 || empty_flag !== 1'b1) && k < 30000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 30000) give_up();
		cyc(2);
	endtask : drain
	// Each decoded character retires the oldest expected one
	always @(posedge clk) begin
		if (rx_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk_bit("unexpected_char", 1'b0, 1'b1);
			end else begin
				cur = exp_q.pop_front();
				chk_word("char", {7'h00, cur[8:0]}, {7'h00, rx_data});
				chk_bit("frame_err", 1'b0, rx_err);
				if (cur[9]) chk_word("gap", 16'h0000, rx_gap);
			end
		end
	end
	// Main sequence
	initial begin
		seed = 32'h8BAF;
		rst = 1'b1;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		cfg = '{port_on: 1'b1, transmitter_on: 1'b1, clocked_mode_select: 1'b0, line_polarity_invert: 1'b0,
			nine_bit_select: 1'b0, ninth_bit_value: 1'b0, rate_16bit: 1'b0, transmit_irq_mask: 1'b0,
			rate_divisor: 16'h0103};
		cyc(6);
		rst = 1'b0;
		cyc(2);
		// Idle flag stands whatever the mask; the mask only gates the request
		chk_bit("flag_idle", 1'b1, free_flag);
		chk_bit("irq_masked", 1'b0, irq_req);
		chk_bit("oe", 1'b1, tx_pin_oe);
		cfg.transmit_irq_mask = 1'b1;
		cyc(2);
		chk_bit("irq_open", 1'b1, irq_req);
		// Overfilling bursts in high-true, low-true and nine-bit formats
		for (int s = 0; s < 3; s++) begin
			cfg.line_polarity_invert = (s == 1);
			cfg.nine_bit_select = (s == 2);
			cyc(2);
			chk_bit("pin_idle", ~cfg.line_polarity_invert, tx_pin_o);
			stalls = 0;
			burst(7, 1'b1);
			chk_bit("fifo_full", 1'b1, stalls > 0);
			chk_bit("flag_busy", 1'b0, free_flag);
			chk_bit("empty_busy", 1'b0, empty_flag);
			cfg.transmit_irq_mask = 1'b0;
			drain();
			chk_bit("flag_done", 1'b1, free_flag);
			chk_bit("empty_done", 1'b1, empty_flag);
			chk_bit("irq_mask_off", 1'b0, irq_req);
			cfg.transmit_irq_mask = 1'b1;
		end
		// A write during a frame leaves the flag up on the write itself
		burst(1, 1'b1);
		cyc(6);
		burst(1, 1'b1);
		chk_bit("flag_on_write", 1'b1, free_flag);
		cyc(3);
		chk_bit("flag_after", 1'b0, free_flag);
		drain();
		// Port off flushes what a disabled transmitter kept and releases the pin
		cfg.transmitter_on = 1'b0;
		cyc(2);
		chk_bit("flag_off", 1'b0, free_flag);
		burst(1, 1'b0);
		cyc(40);
		chk_bit("empty_off", 1'b1, empty_flag);
		chk_bit("pin_off", 1'b1, tx_pin_o);
		cfg.port_on = 1'b0;
		cyc(2);
		chk_bit("oe_off", 1'b0, tx_pin_oe);
		cfg.port_on = 1'b1;
		cfg.transmitter_on = 1'b1;
		cyc(60);
		chk_bit("empty_flush", 1'b1, empty_flag);
		chk_bit("oe_on", 1'b1, tx_pin_oe);
		// A character written while disabled leaves once the transmitter is on
		cfg.transmitter_on = 1'b0;
		cyc(2);
		burst(1, 1'b1);
		cyc(4);
		// Clocked mode keeps the path off even with the transmitter switched on
		cfg.clocked_mode_select = 1'b1;
		cfg.transmitter_on = 1'b1;
		cyc(4);
		chk_bit("flag_clocked", 1'b0, free_flag);
		chk_bit("empty_clocked", 1'b1, empty_flag);
		cfg.clocked_mode_select = 1'b0;
		drain();
		// Wide divisor: a bit spans the full 16-bit count plus one
		cfg.rate_16bit = 1'b1;
		cfg.rate_divisor = 16'h0100;
		cyc(2);
		burst(2, 1'b1);
		drain();
		tally_and_finish();
	end
endmodule : tb_async_serial_transmitter
